// ===== cmi_core_ctrl.sv
// Top: operating mode, stack select, faults, tick timer, debug compare, interrupt intake
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
module cmi_core_ctrl
  import cmi_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Pins from outside
  input wire logic [CMI_IRQ_N-1:0] irq_line,
  input wire logic low_freq_clock,
  // Exception handshake with the core
  output logic irq_req,
  output logic [5:0] irq_num,
  input wire logic exc_entry,
  input wire logic exc_return,
  output logic handler_mode,
  // Stack selection
  input wire logic insn_sync_barrier,
  output logic use_process_stack_ptr,
  // Global masking
  input wire logic global_irq_disable_insn,
  input wire logic global_irq_enable_insn,
  // Condition flags
  input cmi_alu_t alu,
  output logic [3:0] app_condition_flags,
  // Memory access check
  input cmi_mem_req_t mem,
  output logic [3:0] mem_byte_en,
  output logic severe_fault_pending,
  // Instruction state
  input wire logic exec_valid,
  input wire logic exec_state_bit,
  // Multiplier
  input wire logic [31:0] multiply_insn_a,
  input wire logic [31:0] multiply_insn_b,
  output logic [31:0] multiply_insn_result,
  // Debug comparators
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  output logic [CMI_BP_N-1:0] bp_hit,
  output logic [CMI_WP_N-1:0] wp_hit
);

  // =========================================================
  // State
  typedef struct packed {
    logic spsel;
    logic spsel_eff;
    logic saved_spsel;
    logic priority_mask_bit;
    logic [3:0] flags;
    logic [CMI_SRC_N-1:0] act;
    logic [CMI_IRQ_N-1:0] pend;
    logic st_pend;
    logic flt_pend;
    logic [CMI_IRQ_N-1:0] irq_en;
    logic [2*CMI_IRQ_N-1:0] irq_pri;
    logic [1:0] st_pri;
    logic st_en;
    logic st_int;
    logic st_core;
    logic st_flag;
    logic [CMI_ST_W-1:0] st_reload;
    logic [CMI_ST_W-1:0] st_cur;
    logic [CMI_IRQ_N-1:0] irq_s1;
    logic [CMI_IRQ_N-1:0] irq_s2;
    logic [CMI_IRQ_N-1:0] irq_q;
    logic lf_s1;
    logic lf_s2;
    logic lf_q;
    logic [CMI_BP_N+CMI_WP_N-1:0] dbg_en;
    logic [CMI_BP_N-1:0][31:0] bp;
    logic [CMI_WP_N-1:0][31:0] wp;
    logic [CMI_BP_N-1:0] bp_hit;
    logic [CMI_WP_N-1:0] wp_hit;
    logic req;
    logic [5:0] req_num;
    logic [31:0] rdata;
    logic [3:0] be;
    logic [31:0] mul;
  } cmi_state_t;

  cmi_state_t state;
  cmi_state_t next_state;

  // =========================================================
  // Functions

  // Priority of a source slot: lines, else the tick's field
  function automatic logic [2:0] pri_of(input cmi_state_t s, input int slot);
    logic [2:0] p;
    p = {1'b0, s.st_pri};
    if (slot < CMI_IRQ_N) begin
      p = {1'b0, s.irq_pri[2*slot +: 2]};
    end
    return p;
  endfunction : pri_of

  // Byte lanes, lowest address takes lane 0
  function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] a);
    logic [3:0] be;
    case (sz)
      CMI_SZ_BYTE: be = 4'h1 << a;
      CMI_SZ_HALF: be = 4'h3 << a;
      default: be = 4'hF;
    endcase
    return be;
  endfunction : lanes

  // Misaligned access check; bytes are always aligned
  function automatic logic misaligned(input logic [1:0] sz, input logic [1:0] a);
    logic m;
    case (sz)
      CMI_SZ_HALF: m = a[0];
      CMI_SZ_WORD, CMI_SZ_MULTI: m = |a;
      default: m = 1'b0;
    endcase
    return m;
  endfunction : misaligned

  // =========================================================
  // Combinational next state
  always_comb begin
    logic [2:0] cur_pri;
    logic [2:0] best_pri;
    logic [4:0] best;
    logic found;
    logic tick;
    logic st_zero_ev;
    logic [CMI_IRQ_N-1:0] rise;
    logic [CMI_IRQ_N-1:0] leave;
    logic [CMI_SRC_N-1:0] cand;
    logic entering;
    logic returning;
    logic [4:0] top;
    cur_pri = CMI_PRI_NONE;
    best_pri = CMI_PRI_NONE;
    best = 5'h00;
    found = 1'b0;
    tick = 1'b0;
    st_zero_ev = 1'b0;
    leave = '0;
    cand = '0;
    top = 5'h00;
    next_state = state;

    // Two flops on every pin before use
    next_state.irq_s1 = irq_line;
    next_state.irq_s2 = state.irq_s1;
    next_state.irq_q = state.irq_s2;
    next_state.lf_s1 = low_freq_clock;
    next_state.lf_s2 = state.lf_s1;
    next_state.lf_q = state.lf_s2;
    rise = state.irq_s2 & ~state.irq_q;

    // Current running priority from active handlers
    for (int i = 0; i < CMI_SRC_N - 1; i++) begin
      if (state.act[i] && pri_of(state, i) < cur_pri) begin
        cur_pri = pri_of(state, i);
      end
    end

    // Handler to retire on return: the highest-priority active one
    top = 5'(CMI_SLOT_FAULT);
    if (!state.act[CMI_SLOT_FAULT]) begin
      for (int i = CMI_SRC_N - 2; i >= 0; i--) begin
        if (state.act[i] && pri_of(state, i) == cur_pri) begin
          top = 5'(i);
        end
      end
    end

    entering = exc_entry && state.req;
    returning = exc_return && |state.act && !entering;

    // Tick timer source and countdown
    tick = state.st_core ? 1'b1 : (state.lf_s2 && !state.lf_q);
    if (state.st_en && tick) begin
      if (state.st_cur == '0) begin
        next_state.st_cur = state.st_reload;
      end else begin
        next_state.st_cur = state.st_cur - CMI_ST_W'(1);
        st_zero_ev = (state.st_cur == CMI_ST_W'(1));
      end
    end

    // Register reads
    next_state.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        CMI_OFS_CONTROL: next_state.rdata[CMI_CTL_SPSEL] = state.spsel;
        CMI_OFS_PRIORITY_MASK_BIT: next_state.rdata[CMI_PM_BIT] = state.priority_mask_bit;
        CMI_OFS_STATUS: begin
          next_state.rdata[CMI_STS_HANDLER] = |state.act;
          next_state.rdata[CMI_STS_PSP] = state.spsel_eff && !(|state.act);
          next_state.rdata[CMI_STS_NUM +: 6] = state.req_num;
        end
        CMI_OFS_ST_CTRL: begin
          next_state.rdata[CMI_STC_EN] = state.st_en;
          next_state.rdata[CMI_STC_INT] = state.st_int;
          next_state.rdata[CMI_STC_CORE] = state.st_core;
          next_state.rdata[CMI_STC_FLAG] = state.st_flag;
          next_state.st_flag = 1'b0; // Cleared by this read
        end
        CMI_OFS_ST_RELOAD: next_state.rdata[CMI_ST_W-1:0] = state.st_reload;
        CMI_OFS_ST_CURRENT: next_state.rdata[CMI_ST_W-1:0] = state.st_cur;
        CMI_OFS_IRQ_EN: next_state.rdata[CMI_IRQ_N-1:0] = state.irq_en;
        CMI_OFS_IRQ_PRI: next_state.rdata = state.irq_pri;
        CMI_OFS_IRQ_PEND: next_state.rdata[CMI_IRQ_N-1:0] = state.pend;
        CMI_OFS_DBG_EN: next_state.rdata[CMI_BP_N+CMI_WP_N-1:0] = state.dbg_en;
        CMI_OFS_ST_PRI: next_state.rdata[1:0] = state.st_pri;
        default: begin
          for (int i = 0; i < CMI_BP_N; i++) begin
            if (reg_addr == CMI_OFS_BP0 + 8'(4 * i)) next_state.rdata = state.bp[i];
          end
          for (int i = 0; i < CMI_WP_N; i++) begin
            if (reg_addr == CMI_OFS_WP0 + 8'(4 * i)) next_state.rdata = state.wp[i];
          end
        end
      endcase
    end

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        CMI_OFS_CONTROL: begin
          if (!(|state.act)) begin
            next_state.spsel = reg_wdata[CMI_CTL_SPSEL];
          end
        end
        CMI_OFS_PRIORITY_MASK_BIT: next_state.priority_mask_bit = reg_wdata[CMI_PM_BIT];
        CMI_OFS_ST_CTRL: begin
          next_state.st_en = reg_wdata[CMI_STC_EN];
          next_state.st_int = reg_wdata[CMI_STC_INT];
          next_state.st_core = reg_wdata[CMI_STC_CORE];
        end
        CMI_OFS_ST_RELOAD: next_state.st_reload = reg_wdata[CMI_ST_W-1:0];
        CMI_OFS_ST_CURRENT: begin
          next_state.st_cur = '0;
          next_state.st_flag = 1'b0;
        end
        CMI_OFS_IRQ_EN: next_state.irq_en = reg_wdata[CMI_IRQ_N-1:0];
        CMI_OFS_IRQ_PRI: next_state.irq_pri = reg_wdata;
        CMI_OFS_DBG_EN: next_state.dbg_en = reg_wdata[CMI_BP_N+CMI_WP_N-1:0];
        CMI_OFS_ST_PRI: next_state.st_pri = reg_wdata[1:0];
        default: begin
          for (int i = 0; i < CMI_BP_N; i++) begin
            if (reg_addr == CMI_OFS_BP0 + 8'(4 * i)) next_state.bp[i] = reg_wdata;
          end
          for (int i = 0; i < CMI_WP_N; i++) begin
            if (reg_addr == CMI_OFS_WP0 + 8'(4 * i)) next_state.wp[i] = reg_wdata;
          end
        end
      endcase
    end

    // Count-to-zero event; sets win over the clears above
    if (st_zero_ev) begin
      next_state.st_flag = 1'b1;
    end

    // Global mask instructions
    if (global_irq_disable_insn) begin
      next_state.priority_mask_bit = 1'b1;
    end else if (global_irq_enable_insn) begin
      next_state.priority_mask_bit = 1'b0;
    end

    // Flags only on flag-setting forms
    if (alu.valid && alu.set_flags) begin
      next_state.flags = alu.nzcv;
    end

    // Exception entry
    if (entering) begin
      if (!(|state.act)) begin
        next_state.saved_spsel = state.spsel;
      end
      next_state.spsel = 1'b0;
      next_state.spsel_eff = 1'b0;
      if (state.req_num == CMI_EXC_FAULT) begin
        next_state.flt_pend = 1'b0;
        next_state.act[CMI_SLOT_FAULT] = 1'b1;
      end else if (state.req_num == CMI_EXC_TICK) begin
        next_state.st_pend = 1'b0;
        next_state.act[CMI_SLOT_TICK] = 1'b1;
      end else begin
        next_state.pend[4'(state.req_num - CMI_EXC_IRQ0)] = 1'b0;
        next_state.act[4'(state.req_num - CMI_EXC_IRQ0)] = 1'b1;
      end
    end

    // Exception return
    if (returning) begin
      next_state.act[top] = 1'b0;
      if (top < 5'(CMI_IRQ_N)) begin
        leave[4'(top)] = 1'b1;
      end
      if (state.act == (CMI_SRC_N'(1) << top)) begin
        next_state.spsel = state.saved_spsel;
        next_state.spsel_eff = state.saved_spsel;
      end
    end

    // Barrier makes a moved stack choice visible
    if (insn_sync_barrier) begin
      next_state.spsel_eff = state.spsel;
    end

    // Pending: rising edge, or level still high when its handler ends
    next_state.pend = next_state.pend | rise | (leave & state.irq_s2);
    if (st_zero_ev && state.st_int) begin
      next_state.st_pend = 1'b1;
    end

    // Faults from misaligned access and clear instruction-state bit
    if (mem.valid && misaligned(mem.size, mem.addr[1:0])) begin
      next_state.flt_pend = 1'b1;
    end
    if (exec_valid && !exec_state_bit) begin
      next_state.flt_pend = 1'b1;
    end

    // Priority resolution over enabled lines and the tick
    cand[CMI_IRQ_N-1:0] = state.pend & state.irq_en;
    cand[CMI_SLOT_TICK] = state.st_pend;
    for (int i = CMI_SRC_N - 2; i >= 0; i--) begin
      if (cand[i] && pri_of(state, i) <= best_pri) begin
        best_pri = pri_of(state, i);
        best = 5'(i);
        found = 1'b1;
      end
    end

    // Request to core; fault ignores the mask, others need higher priority
    next_state.req = 1'b0;
    next_state.req_num = state.req_num;
    if (entering || returning) begin
      next_state.req = 1'b0; // Re-evaluate after the mode change
    end else if (state.flt_pend && !state.act[CMI_SLOT_FAULT]) begin
      next_state.req = 1'b1;
      next_state.req_num = CMI_EXC_FAULT;
    end else if (found && !state.priority_mask_bit && !state.act[CMI_SLOT_FAULT] && best_pri < cur_pri) begin
      next_state.req = 1'b1;
      next_state.req_num = (best == 5'(CMI_SLOT_TICK)) ? CMI_EXC_TICK :
        CMI_EXC_IRQ0 + 6'(best);
    end

    // Little-endian byte lanes and multiply low word
    next_state.be = mem.valid ? lanes(mem.size, mem.addr[1:0]) : 4'h0;
    next_state.mul = 32'(multiply_insn_a * multiply_insn_b);

    // Debug comparators
    for (int i = 0; i < CMI_BP_N; i++) begin
      next_state.bp_hit[i] = state.dbg_en[i] && fetch_valid && fetch_addr == state.bp[i];
    end
    for (int i = 0; i < CMI_WP_N; i++) begin
      next_state.wp_hit[i] = state.dbg_en[CMI_BP_N+i] && mem.valid && mem.addr == state.wp[i];
    end
  end

  // =========================================================
  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '0;
      state.st_core <= CMI_RST_ST_CTRL[CMI_STC_CORE];
    end else begin
      state <= next_state;
    end
  end

  // =========================================================
  // Outputs
  assign reg_rdata = state.rdata;
  assign irq_req = state.req;
  assign irq_num = state.req_num;
  assign handler_mode = |state.act;
  assign use_process_stack_ptr = state.spsel_eff && !(|state.act);
  assign app_condition_flags = state.flags;
  assign mem_byte_en = state.be;
  assign severe_fault_pending = state.flt_pend;
  assign multiply_insn_result = state.mul;
  assign bp_hit = state.bp_hit;
  assign wp_hit = state.wp_hit;

endmodule : cmi_core_ctrl

// ===== cmi_pkg.sv
// Package: constants and types for the mode, stack and interrupt intake block
package cmi_pkg;
  // ===========================================================
  // Sizes
  localparam int CMI_IRQ_N = 16;
  localparam int CMI_ST_W = 24;
  localparam int CMI_BP_N = 4;
  localparam int CMI_WP_N = 2;
  localparam int CMI_SRC_N = 18;
  // ===========================================================
  // Register byte offsets
  localparam logic [7:0] CMI_OFS_CONTROL = 8'h00;
  localparam logic [7:0] CMI_OFS_PRIORITY_MASK_BIT = 8'h04;
  localparam logic [7:0] CMI_OFS_STATUS = 8'h08;
  localparam logic [7:0] CMI_OFS_ST_CTRL = 8'h0C;
  localparam logic [7:0] CMI_OFS_ST_RELOAD = 8'h10;
  localparam logic [7:0] CMI_OFS_ST_CURRENT = 8'h14;
  localparam logic [7:0] CMI_OFS_IRQ_EN = 8'h18;
  localparam logic [7:0] CMI_OFS_IRQ_PRI = 8'h1C;
  localparam logic [7:0] CMI_OFS_IRQ_PEND = 8'h20;
  localparam logic [7:0] CMI_OFS_DBG_EN = 8'h24;
  localparam logic [7:0] CMI_OFS_BP0 = 8'h28;
  localparam logic [7:0] CMI_OFS_WP0 = 8'h38;
  localparam logic [7:0] CMI_OFS_ST_PRI = 8'h40;
  // ===========================================================
  // Field positions
  localparam int CMI_CTL_SPSEL = 1;
  localparam int CMI_PM_BIT = 0;
  localparam int CMI_STC_EN = 0;
  localparam int CMI_STC_INT = 1;
  localparam int CMI_STC_CORE = 2;
  localparam int CMI_STC_FLAG = 16;
  localparam int CMI_STS_HANDLER = 0;
  localparam int CMI_STS_PSP = 1;
  localparam int CMI_STS_NUM = 8;
  // ===========================================================
  // Exception numbers and source slots
  localparam logic [5:0] CMI_EXC_FAULT = 6'h03;
  localparam logic [5:0] CMI_EXC_TICK = 6'h0F;
  localparam logic [5:0] CMI_EXC_IRQ0 = 6'h10;
  localparam int CMI_SLOT_TICK = 16;
  localparam int CMI_SLOT_FAULT = 17;
  localparam logic [2:0] CMI_PRI_NONE = 3'h4;
  // ===========================================================
  // Access sizes
  localparam logic [1:0] CMI_SZ_BYTE = 2'h0;
  localparam logic [1:0] CMI_SZ_HALF = 2'h1;
  localparam logic [1:0] CMI_SZ_WORD = 2'h2;
  localparam logic [1:0] CMI_SZ_MULTI = 2'h3;
  // ===========================================================
  // Reset values
  localparam logic [31:0] CMI_RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] CMI_RST_ST_CTRL = 32'h0000_0004;
  // ===========================================================
  // Port carriers
  typedef struct packed {
    logic valid;
    logic [1:0] size;
    logic [31:0] addr;
  } cmi_mem_req_t;
  typedef struct packed {
    logic valid;
    logic set_flags;
    logic [3:0] nzcv;
  } cmi_alu_t;
endpackage : cmi_pkg

// ===== cmi_irq_src.sv
// Partner: interrupt sources and slow clock
`timescale 1ns/1ps
module cmi_irq_src
  import cmi_pkg::*;
(
  // Clock
  input wire logic clk,
  // Lines into the block
  output logic [CMI_IRQ_N-1:0] irq_line,
  output logic low_freq_clock
);
  // Idle lines
  initial begin
    irq_line = '0;
    low_freq_clock = 1'b0;
  end
  // Pulse source, three cycles
  task automatic pulse(input logic [CMI_IRQ_N-1:0] m);
    @(posedge clk);
    irq_line <= irq_line | m;
    repeat (3) @(posedge clk);
    irq_line <= irq_line & ~m;
  endtask : pulse
  // Level source
  task automatic level(input int n, input logic v);
    @(posedge clk);
    irq_line[n] <= v;
  endtask : level
  // Slow clock bursts, free phase
  task automatic lf_ticks(input int k);
    repeat (k) begin
      #173 low_freq_clock = 1'b1;
      #173 low_freq_clock = 1'b0;
    end
  endtask : lf_ticks
endmodule : cmi_irq_src

// ===== cmi_core_ctrl_sva.sv
// Checker for the mode, stack and interrupt intake block
`timescale 1ns/1ps
module cmi_core_ctrl_sva
  import cmi_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Observed ports
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic irq_req,
  input wire logic exc_entry,
  input wire logic handler_mode,
  input wire logic use_process_stack_ptr,
  input cmi_alu_t alu,
  input wire logic [3:0] app_condition_flags,
  input cmi_mem_req_t mem,
  input wire logic [3:0] mem_byte_en,
  input wire logic severe_fault_pending,
  input wire logic exec_valid,
  input wire logic exec_state_bit,
  input wire logic [31:0] multiply_insn_a,
  input wire logic [31:0] multiply_insn_b,
  input wire logic [31:0] multiply_insn_result
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Helpers
  logic [1:0] lane;
  logic [31:0] prod;
  logic misaligned;
  assign lane = mem.addr[1:0];
  assign prod = multiply_insn_a * multiply_insn_b;
  assign misaligned = (mem.size == CMI_SZ_HALF) ? lane[0] : (mem.size != CMI_SZ_BYTE && |lane);
  // ===========================================================
  // Properties
  a_handler_main_stack: assert property (handler_mode |-> !use_process_stack_ptr)
    else $error("psp in handler");
  a_rdata_one_cycle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("stray read data");
  a_misalign_fault: assert property (mem.valid && misaligned |-> ##[1:2] severe_fault_pending)
    else $error("no align fault");
  a_lane_select: assert property (mem.valid && mem.size == CMI_SZ_BYTE |=> mem_byte_en == 4'h1 << $past(lane))
    else $error("wrong lane");
  a_flags_hold: assert property (!(alu.valid && alu.set_flags) |=> $stable(app_condition_flags))
    else $error("flags moved");
  a_flags_load: assert property (alu.valid && alu.set_flags |=> app_condition_flags == $past(alu.nzcv))
    else $error("flags not loaded");
  a_mul_low_word: assert property (1'b1 |=> multiply_insn_result == $past(prod))
    else $error("bad product");
  a_entry_takes_req: assert property (irq_req && exc_entry |=> !irq_req && handler_mode)
    else $error("entry ignored");
  a_state_bit_fault: assert property (exec_valid && !exec_state_bit |-> ##[1:2] severe_fault_pending)
    else $error("no state fault");
endmodule : cmi_core_ctrl_sva
bind cmi_core_ctrl cmi_core_ctrl_sva i_sva (.clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq_req(irq_req), .exc_entry(exc_entry), .handler_mode(handler_mode),
  .use_process_stack_ptr(use_process_stack_ptr), .alu(alu), .app_condition_flags(app_condition_flags),
  .mem(mem), .mem_byte_en(mem_byte_en), .severe_fault_pending(severe_fault_pending), .exec_valid(exec_valid),
  .exec_state_bit(exec_state_bit), .multiply_insn_a(multiply_insn_a), .multiply_insn_b(multiply_insn_b),
  .multiply_insn_result(multiply_insn_result));

// ===== test_cpu_mode_stack_and_irq_intake.sv
// Self-checking bench for the mode, stack and interrupt intake block
`timescale 1ns/1ps
module test_cpu_mode_stack_and_irq_intake;
  import cmi_pkg::*;
  // ===========================================================
  // Signals and counters
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, exc_entry = 1'b0, exc_return = 1'b0;
  logic insn_sync_barrier = 1'b0, global_irq_disable_insn = 1'b0, global_irq_enable_insn = 1'b0;
  logic exec_valid = 1'b0, exec_state_bit = 1'b1, fetch_valid = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, multiply_insn_a = 32'h0, multiply_insn_b = 32'h0, fetch_addr = 32'h0;
  logic [31:0] reg_rdata, multiply_insn_result, r1;
  cmi_alu_t alu = '0;
  cmi_mem_req_t mem = '0;
  logic [CMI_IRQ_N-1:0] irq_line;
  logic low_freq_clock, irq_req, handler_mode, use_process_stack_ptr, severe_fault_pending;
  logic [5:0] irq_num;
  logic [3:0] app_condition_flags, mem_byte_en, bp_hit;
  logic [1:0] wp_hit;
  int n_fail = 0, tests_run = 0;
  // Alignment cases
  logic [1:0] msz [8] = '{CMI_SZ_BYTE, CMI_SZ_HALF, CMI_SZ_HALF, CMI_SZ_WORD, CMI_SZ_WORD, CMI_SZ_MULTI,
    CMI_SZ_MULTI, CMI_SZ_BYTE};
  logic [1:0] mlo [8] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h2, 2'h0, 2'h1, 2'h1};
  logic [3:0] mbe [8] = '{4'h8, 4'hC, 4'h0, 4'hF, 4'h0, 4'hF, 4'h0, 4'h2};
  logic mflt [8] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  // Clock at 25 MHz
  always #20 clk = ~clk;
  // ===========================================================
  // Block and partner
  cmi_core_ctrl i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_line(irq_line), .low_freq_clock(low_freq_clock),
    .irq_req(irq_req), .irq_num(irq_num), .exc_entry(exc_entry), .exc_return(exc_return),
    .handler_mode(handler_mode), .insn_sync_barrier(insn_sync_barrier),
    .use_process_stack_ptr(use_process_stack_ptr), .global_irq_disable_insn(global_irq_disable_insn),
    .global_irq_enable_insn(global_irq_enable_insn), .alu(alu), .app_condition_flags(app_condition_flags),
    .mem(mem), .mem_byte_en(mem_byte_en), .severe_fault_pending(severe_fault_pending), .exec_valid(exec_valid),
    .exec_state_bit(exec_state_bit), .multiply_insn_a(multiply_insn_a), .multiply_insn_b(multiply_insn_b),
    .multiply_insn_result(multiply_insn_result), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .bp_hit(bp_hit), .wp_hit(wp_hit));
  cmi_irq_src i_src (.clk(clk), .irq_line(irq_line), .low_freq_clock(low_freq_clock));
  // ===========================================================
  // Tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic done(input string m);
    $display("test %s finished", m);
  endtask : done
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read, data in answer cycle
  task automatic rdv(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rdv
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
    logic [31:0] d;
    rdv(a, d);
    chk(d, e, m);
  endtask : rdc
  // One-cycle strobes: 0 barrier, 1 disable, 2 enable, 3 exec good, 4 exec bad state
  task automatic strobe(input int w);
    @(posedge clk);
    insn_sync_barrier <= (w == 0);
    global_irq_disable_insn <= (w == 1);
    global_irq_enable_insn <= (w == 2);
    exec_valid <= (w >= 3);
    exec_state_bit <= (w != 4);
    @(posedge clk);
    {insn_sync_barrier, global_irq_disable_insn, global_irq_enable_insn, exec_valid} <= 4'h0;
    exec_state_bit <= 1'b1;
    cyc(1);
  endtask : strobe
  // Await request, check number, enter
  task automatic enter(input logic [5:0] n);
    int k;
    k = 0;
    while (irq_req !== 1'b1 && k < 150) begin
      @(posedge clk);
      #1 k++;
    end
    chk(irq_req, 1'b1, "no request");
    chk(irq_num, n, "request number");
    @(posedge clk);
    exc_entry <= 1'b1;
    @(posedge clk);
    exc_entry <= 1'b0;
    #1 chk(handler_mode, 1'b1, "entry mode");
  endtask : enter
  task automatic leave;
    @(posedge clk);
    exc_return <= 1'b1;
    @(posedge clk);
    exc_return <= 1'b0;
    cyc(1);
  endtask : leave
  task automatic memx(input logic [1:0] s, input logic [31:0] a);
    @(posedge clk);
    mem <= '{valid: 1'b1, size: s, addr: a};
    @(posedge clk);
    mem.valid <= 1'b0;
    #1;
  endtask : memx
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  // ===========================================================
  // Watchdog
  initial begin
    #(40 * 20000);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdc(CMI_OFS_CONTROL, CMI_RST_ZERO, "control reset");
    rdc(CMI_OFS_ST_CTRL, CMI_RST_ST_CTRL, "tick control reset");
    chk(use_process_stack_ptr, 1'b0, "msp at reset");
    wr(8'hFC, 32'hFFFF_FFFF);
    rdc(8'hFC, 32'h0, "unmapped read");
    wr(CMI_OFS_ST_RELOAD, 32'hFFFF_FFFF);
    rdc(CMI_OFS_ST_RELOAD, 32'h00FF_FFFF, "reload width");
    done("reset");
    wr(CMI_OFS_CONTROL, 32'h2);
    cyc(2);
    chk(use_process_stack_ptr, 1'b0, "early switch");
    strobe(0);
    chk(use_process_stack_ptr, 1'b1, "psp in thread");
    done("stack");
    wr(CMI_OFS_IRQ_EN, 32'h0000_FFF7);
    wr(CMI_OFS_IRQ_PRI, 32'h0000_000C);
    i_src.pulse(16'h0006);
    enter(CMI_EXC_IRQ0 + 6'h2);
    chk(use_process_stack_ptr, 1'b0, "msp in handler");
    wr(CMI_OFS_CONTROL, 32'h2);
    rdc(CMI_OFS_CONTROL, 32'h0, "control in handler");
    cyc(8);
    chk(irq_req, 1'b0, "low pri preempts");
    leave();
    chk(use_process_stack_ptr, 1'b1, "psp restored");
    enter(CMI_EXC_IRQ0 + 6'h1);
    leave();
    i_src.pulse(16'h0008);
    cyc(10);
    chk(irq_req, 1'b0, "disabled line");
    i_src.level(4, 1'b1);
    enter(CMI_EXC_IRQ0 + 6'h4);
    leave();
    enter(CMI_EXC_IRQ0 + 6'h4);
    i_src.level(4, 1'b0);
    cyc(4);
    leave();
    cyc(8);
    chk(irq_req, 1'b0, "stale level");
    done("interrupts");
    strobe(1);
    rdc(CMI_OFS_PRIORITY_MASK_BIT, 32'h1, "mask bit set");
    i_src.pulse(16'h0040);
    cyc(8);
    chk(irq_req, 1'b0, "masked line");
    strobe(3);
    chk(severe_fault_pending, 1'b0, "false fault");
    strobe(4);
    chk(severe_fault_pending, 1'b1, "state fault");
    enter(CMI_EXC_FAULT);
    leave();
    strobe(2);
    enter(CMI_EXC_IRQ0 + 6'h6);
    leave();
    done("masking");
    for (int i = 0; i < 8; i++) begin
      memx(msz[i], 32'h0000_0100 | 32'(mlo[i]));
      if (!mflt[i] && msz[i] != CMI_SZ_MULTI) chk(mem_byte_en, mbe[i], "byte lanes");
      cyc(1);
      chk(severe_fault_pending, mflt[i], "alignment fault");
      if (mflt[i]) begin
        enter(CMI_EXC_FAULT);
        leave();
      end
    end
    @(posedge clk);
    alu <= '{valid: 1'b1, set_flags: 1'b1, nzcv: 4'hA};
    multiply_insn_a <= 32'hFFFF_FFFF;
    multiply_insn_b <= 32'h0000_0003;
    @(posedge clk);
    alu <= '{valid: 1'b1, set_flags: 1'b0, nzcv: 4'h5};
    #1 chk(app_condition_flags, 4'hA, "flags load");
    chk(multiply_insn_result, 32'hFFFF_FFFD, "product low word");
    @(posedge clk);
    alu.valid <= 1'b0;
    #1 chk(app_condition_flags, 4'hA, "flags held");
    done("datapath");
    wr(CMI_OFS_ST_PRI, 32'h0);
    wr(CMI_OFS_ST_RELOAD, 32'h0000_0040);
    wr(CMI_OFS_ST_CTRL, 32'h0000_0007);
    enter(CMI_EXC_TICK);
    wr(CMI_OFS_ST_CTRL, 32'h0000_0004);
    leave();
    wr(CMI_OFS_ST_CURRENT, 32'h0);
    wr(CMI_OFS_ST_RELOAD, 32'h0000_0020);
    wr(CMI_OFS_ST_CTRL, 32'h0000_0001);
    i_src.lf_ticks(2);
    rdv(CMI_OFS_ST_CURRENT, r1);
    cyc(20);
    rdc(CMI_OFS_ST_CURRENT, r1, "core clock tick");
    i_src.lf_ticks(4);
    cyc(4);
    rdc(CMI_OFS_ST_CURRENT, r1 - 32'h4, "slow clock count");
    wr(CMI_OFS_ST_CTRL, 32'h0000_0004);
    done("tick");
    wr(CMI_OFS_DBG_EN, 32'h0000_003F);
    for (int i = 0; i < 4; i++) wr(CMI_OFS_BP0 + 8'(4 * i), 32'h0000_0100 + 32'(16 * i));
    for (int i = 0; i < 2; i++) wr(CMI_OFS_WP0 + 8'(4 * i), 32'h2000_0000 + 32'(4 * i));
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      fetch_valid <= 1'b1;
      fetch_addr <= 32'h0000_0100 + 32'(16 * i);
      @(posedge clk);
      fetch_valid <= 1'b0;
      #1 chk(bp_hit, 32'h1 << i, "breakpoint hit");
      if (i < 2) begin
        memx(CMI_SZ_BYTE, 32'h2000_0000 + 32'(4 * i));
        chk(wp_hit, 32'h1 << i, "watchpoint hit");
      end
    end
    done("debug");
    final_report();
  end
endmodule : test_cpu_mode_stack_and_irq_intake
